// *** inc/cpu_pkg.sv ***
// Constants and types shared by the opcode decoder and the sequencer
package cpu_pkg;
    // High nibble of an opcode selects the operation
    localparam logic [3:0] NIB_INC = 4'h0;
    localparam logic [3:0] NIB_DECR = 4'h1;
    localparam logic [3:0] NIB_ADD = 4'h2;
    localparam logic [3:0] NIB_ADD_CY = 4'h3;
    localparam logic [3:0] NIB_AND = 4'h5;
    localparam logic [3:0] NIB_SUB_BW = 4'h9;
    // Low nibble selects the operand form
    localparam logic [3:0] LO_DIR_ACC = 4'h2;
    localparam logic [3:0] LO_DIR_IMM = 4'h3;
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIR = 4'h5;
    localparam logic [2:0] LO_IND = 3'h3;
    localparam int LO_REG_BIT = 3;
    // Instruction lengths in bytes
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    // Instruction times in core clock cycles
    localparam logic [2:0] CYC_1 = 3'h1;
    localparam logic [2:0] CYC_2 = 3'h2;
    localparam logic [2:0] CYC_3 = 3'h3;
    localparam logic [2:0] CYC_4 = 3'h4;
    localparam logic [2:0] CYC_5 = 3'h5;
    // Status word layout
    localparam int STAT_CY = 7;
    localparam int STAT_AC = 6;
    localparam int STAT_BANK_HI = 4;
    localparam int STAT_BANK_LO = 3;
    localparam int STAT_OV = 2;
    localparam int STAT_PAR = 0;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [2:0] BANK_TOP = 3'h0;
    localparam logic [1:0] PTR_PAD = 2'h0;

    typedef enum logic [5:0] {
        ALU_ADD = 6'h01,
        ALU_ADD_CY = 6'h02,
        ALU_SUB_BW = 6'h04,
        ALU_INC = 6'h08,
        ALU_DECR = 6'h10,
        ALU_AND = 6'h20
    } alu_op_t;

    typedef enum logic [4:0] {
        SRC_REG = 5'h01,
        SRC_DIR = 5'h02,
        SRC_IND = 5'h04,
        SRC_IMM = 5'h08,
        SRC_ACC = 5'h10
    } src_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_PTR = 5'h02,
        ST_OPND = 5'h04,
        ST_WRITE = 5'h08,
        ST_HOLD = 5'h10
    } state_t;

    typedef struct packed {
        logic valid;
        alu_op_t op;
        src_t src;
        logic to_mem;
        logic imm2;
        logic [1:0] len;
        logic [2:0] cycles;
    } form_t;
endpackage : cpu_pkg

// *** inc/opcode_form_if.sv ***
// Opcode and decoded instruction form between sequencer and decoder
`timescale 1ns/1ps
interface opcode_form_if;
    logic [7:0] opcode;
    cpu_pkg::form_t form;
    modport core (output opcode, input form);
    modport decoder (input opcode, output form);
endinterface : opcode_form_if

// *** logic/opcode_decoder.sv ***
// Opcode to instruction form, length and cycle count
`timescale 1ns/1ps
module opcode_decoder (
    opcode_form_if.decoder fbus
);
    always_comb begin
        logic [3:0] hi;
        logic [3:0] lo;
        logic step;
        cpu_pkg::form_t f;
        hi = fbus.opcode[7:4];
        lo = fbus.opcode[3:0];
        step = (hi == cpu_pkg::NIB_INC) || (hi == cpu_pkg::NIB_DECR);
        f = '0;
        f.valid = 1'b1;
        // Operation from the high nibble
        if (hi == cpu_pkg::NIB_ADD) begin
            f.op = cpu_pkg::ALU_ADD;
        end else if (hi == cpu_pkg::NIB_ADD_CY) begin
            f.op = cpu_pkg::ALU_ADD_CY;
        end else if (hi == cpu_pkg::NIB_SUB_BW) begin
            f.op = cpu_pkg::ALU_SUB_BW;
        end else if (hi == cpu_pkg::NIB_INC) begin
            f.op = cpu_pkg::ALU_INC;
        end else if (hi == cpu_pkg::NIB_DECR) begin
            f.op = cpu_pkg::ALU_DECR;
        end else if (hi == cpu_pkg::NIB_AND) begin
            f.op = cpu_pkg::ALU_AND;
        end else begin
            f.valid = 1'b0;
        end
        // Operand form from the low nibble
        f.to_mem = step;
        if (lo[cpu_pkg::LO_REG_BIT]) begin
            f.src = cpu_pkg::SRC_REG;
            f.len = cpu_pkg::LEN_1;
            f.cycles = step ? cpu_pkg::CYC_3 : cpu_pkg::CYC_2;
        end else if (lo[3:1] == cpu_pkg::LO_IND) begin
            f.src = cpu_pkg::SRC_IND;
            f.len = cpu_pkg::LEN_1;
            f.cycles = step ? cpu_pkg::CYC_5 : cpu_pkg::CYC_4;
            // Add through a pointer has no code here
            f.valid = f.valid && (hi != cpu_pkg::NIB_ADD);
        end else if (lo == cpu_pkg::LO_DIR) begin
            f.src = cpu_pkg::SRC_DIR;
            f.len = cpu_pkg::LEN_2;
            if (step) begin
                f.cycles = cpu_pkg::CYC_4;
            end else if (hi == cpu_pkg::NIB_SUB_BW) begin
                f.cycles = cpu_pkg::CYC_2;
            end else begin
                f.cycles = cpu_pkg::CYC_3;
            end
        end else if (lo == cpu_pkg::LO_IMM) begin
            f.src = step ? cpu_pkg::SRC_ACC : cpu_pkg::SRC_IMM;
            f.to_mem = 1'b0;
            f.len = step ? cpu_pkg::LEN_1 : cpu_pkg::LEN_2;
            f.cycles = step ? cpu_pkg::CYC_1 : cpu_pkg::CYC_2;
        end else if ((lo == cpu_pkg::LO_DIR_ACC) && (hi == cpu_pkg::NIB_AND)) begin
            f.src = cpu_pkg::SRC_DIR;
            f.to_mem = 1'b1;
            f.len = cpu_pkg::LEN_2;
            f.cycles = cpu_pkg::CYC_4;
        end else if ((lo == cpu_pkg::LO_DIR_IMM) && (hi == cpu_pkg::NIB_AND)) begin
            f.src = cpu_pkg::SRC_DIR;
            f.to_mem = 1'b1;
            f.imm2 = 1'b1;
            f.len = cpu_pkg::LEN_3;
            f.cycles = cpu_pkg::CYC_4;
        end else begin
            f.valid = 1'b0;
        end
        fbus.form = f;
    end
endmodule : opcode_decoder

// *** logic/cpu_arith_logic_decode.sv ***
// Sequencer executing the arithmetic and AND instruction forms
`timescale 1ns/1ps

module cpu_arith_logic_decode (
    input logic core_clk,
    input logic srst,
    input logic issue_valid,
    output logic issue_ready,
    input logic [7:0] opcode,
    input logic [7:0] operand1,
    input logic [7:0] operand2,
    output logic [7:0] ram_addr,
    output logic [7:0] ram_wdata,
    output logic ram_we,
    input logic [7:0] ram_rdata,
    input logic acc_we,
    input logic [7:0] acc_wdata,
    input logic status_we,
    input logic [7:0] status_wdata,
    output logic [7:0] acc,
    output logic [7:0] status_word,
    output logic [1:0] inst_len,
    output logic done,
    output logic illegal
);
    typedef struct packed {
        cpu_pkg::state_t st;
        cpu_pkg::form_t f;
        logic [7:0] acc;
        logic [7:0] stat;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic [7:0] imm;
        logic [2:0] cnt;
        logic [1:0] len;
        logic done;
        logic illegal;
    } core_state_t;

    typedef struct packed {
        logic [7:0] res;
        logic cy;
        logic ac;
        logic ov;
        logic flags;
    } alu_out_t;

    core_state_t state_ff;
    core_state_t nxt_state;

    opcode_form_if fbus ();

    opcode_decoder opcode_decoder_i (
        .fbus(fbus)
    );

    assign fbus.opcode = opcode;

    // One operation on a and b; carry in only for the carry forms
    function automatic alu_out_t alu(
        input cpu_pkg::alu_op_t op,
        input logic [7:0] a,
        input logic [7:0] b,
        input logic cin
    );
        logic [8:0] wide;
        logic [4:0] nib;
        logic c;
        alu_out_t r;
        wide = {1'b0, a};
        nib = 5'h00;
        r = '0;
        c = (op == cpu_pkg::ALU_ADD) ? 1'b0 : cin;
        case (op)
            cpu_pkg::ALU_ADD, cpu_pkg::ALU_ADD_CY: begin
                wide = {1'b0, a} + {1'b0, b} + {8'h00, c};
                nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
                r.ov = (a[7] ~^ b[7]) & (a[7] ^ wide[7]);
                r.flags = 1'b1;
            end
            cpu_pkg::ALU_SUB_BW: begin
                wide = {1'b0, a} - {1'b0, b} - {8'h00, c};
                nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
                r.ov = (a[7] ^ b[7]) & (a[7] ^ wide[7]);
                r.flags = 1'b1;
            end
            cpu_pkg::ALU_INC: begin
                wide = {1'b0, a} + 9'h001;
            end
            cpu_pkg::ALU_DECR: begin
                wide = {1'b0, a} - 9'h001;
            end
            cpu_pkg::ALU_AND: begin
                wide = {1'b0, a & b};
            end
            default: begin
                wide = {1'b0, a};
            end
        endcase
        r.res = wide[7:0];
        r.cy = wide[8];
        r.ac = nib[4];
        alu = r;
    endfunction : alu

    always_comb begin
        cpu_pkg::form_t f;
        alu_out_t r;
        logic [1:0] bank;
        logic [7:0] m;
        logic [7:0] a;
        logic [7:0] b;
        logic last;
        f = fbus.form;
        r = '0;
        bank = {state_ff.stat[cpu_pkg::STAT_BANK_HI], state_ff.stat[cpu_pkg::STAT_BANK_LO]};
        m = (state_ff.f.src == cpu_pkg::SRC_IMM) ? state_ff.imm : ram_rdata;
        a = state_ff.acc;
        b = m;
        last = (state_ff.cnt == cpu_pkg::CYC_1);
        nxt_state = state_ff;
        nxt_state.we = 1'b0;
        nxt_state.done = 1'b0;
        nxt_state.illegal = 1'b0;
        // Core writes land first; an instruction writing acc or flags in the same cycle overrides them
        if (acc_we) begin
            nxt_state.acc = acc_wdata;
        end
        if (status_we) begin
            nxt_state.stat = status_wdata;
        end
        case (state_ff.st)
            cpu_pkg::ST_IDLE: begin
                if (issue_valid) begin
                    if (!f.valid) begin
                        nxt_state.illegal = 1'b1;
                    end else begin
                        nxt_state.f = f;
                        nxt_state.len = f.len;
                        nxt_state.cnt = f.cycles - 3'h1;
                        nxt_state.imm = (f.src == cpu_pkg::SRC_IMM) ? operand1 : operand2;
                        if (f.src == cpu_pkg::SRC_REG) begin
                            nxt_state.addr = {cpu_pkg::BANK_TOP, bank, opcode[2:0]};
                        end else if (f.src == cpu_pkg::SRC_IND) begin
                            nxt_state.addr = {cpu_pkg::BANK_TOP, bank, cpu_pkg::PTR_PAD,
                                              opcode[0]};
                        end else begin
                            nxt_state.addr = operand1;
                        end
                        if (f.src == cpu_pkg::SRC_ACC) begin
                            // Single-cycle accumulator step
                            r = alu(f.op, state_ff.acc, 8'h00, 1'b0);
                            nxt_state.acc = r.res;
                            nxt_state.done = 1'b1;
                        end else if (f.src == cpu_pkg::SRC_IND) begin
                            nxt_state.st = cpu_pkg::ST_PTR;
                        end else begin
                            nxt_state.st = cpu_pkg::ST_OPND;
                        end
                    end
                end
            end
            cpu_pkg::ST_PTR: begin
                // Pointer register contents become the operand address
                nxt_state.addr = ram_rdata;
                nxt_state.cnt = state_ff.cnt - 3'h1;
                nxt_state.st = cpu_pkg::ST_OPND;
            end
            cpu_pkg::ST_OPND: begin
                if (state_ff.f.to_mem) begin
                    a = m;
                    b = state_ff.f.imm2 ? state_ff.imm : state_ff.acc;
                end
                r = alu(state_ff.f.op, a, b, state_ff.stat[cpu_pkg::STAT_CY]);
                nxt_state.cnt = state_ff.cnt - 3'h1;
                if (state_ff.f.to_mem) begin
                    // Read-modify-write back to the same location
                    nxt_state.wdata = r.res;
                    nxt_state.we = 1'b1;
                    nxt_state.st = cpu_pkg::ST_WRITE;
                end else begin
                    nxt_state.acc = r.res;
                    if (r.flags) begin
                        nxt_state.stat[cpu_pkg::STAT_CY] = r.cy;
                        nxt_state.stat[cpu_pkg::STAT_AC] = r.ac;
                        nxt_state.stat[cpu_pkg::STAT_OV] = r.ov;
                    end
                    if (last) begin
                        nxt_state.st = cpu_pkg::ST_IDLE;
                        nxt_state.done = 1'b1;
                    end else begin
                        nxt_state.st = cpu_pkg::ST_HOLD;
                    end
                end
            end
            cpu_pkg::ST_WRITE, cpu_pkg::ST_HOLD: begin
                // Pad out to the instruction's full cycle count
                nxt_state.cnt = state_ff.cnt - 3'h1;
                if (last) begin
                    nxt_state.st = cpu_pkg::ST_IDLE;
                    nxt_state.done = 1'b1;
                end else begin
                    nxt_state.st = cpu_pkg::ST_HOLD;
                end
            end
            default: begin
                nxt_state.st = cpu_pkg::ST_IDLE;
            end
        endcase
        // Parity always follows the accumulator
        nxt_state.stat[cpu_pkg::STAT_PAR] = ^nxt_state.acc;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_ff <= '0;
            state_ff.st <= cpu_pkg::ST_IDLE;
            state_ff.acc <= cpu_pkg::ACC_RST;
            state_ff.stat <= cpu_pkg::STAT_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign issue_ready = (state_ff.st == cpu_pkg::ST_IDLE);
    assign ram_addr = state_ff.addr;
    assign ram_wdata = state_ff.wdata;
    assign ram_we = state_ff.we;
    assign acc = state_ff.acc;
    assign status_word = state_ff.stat;
    assign inst_len = state_ff.len;
    assign done = state_ff.done;
    assign illegal = state_ff.illegal;
endmodule : cpu_arith_logic_decode

// *** testbench/cpu_arith_logic_decode_chk.sv ***
// Port-level assertions for the arithmetic and AND instruction sequencer
`timescale 1ns/1ps
module cpu_arith_logic_decode_chk (
    input logic core_clk,
    input logic srst,
    input logic issue_valid,
    input logic issue_ready,
    input logic [7:0] opcode,
    input logic [7:0] operand1,
    input logic [7:0] operand2,
    input logic [7:0] ram_addr,
    input logic [7:0] ram_wdata,
    input logic ram_we,
    input logic [7:0] ram_rdata,
    input logic acc_we,
    input logic [7:0] acc_wdata,
    input logic status_we,
    input logic [7:0] status_wdata,
    input logic [7:0] acc,
    input logic [7:0] status_word,
    input logic [1:0] inst_len,
    input logic done,
    input logic illegal
);
    logic tk;
    assign tk = issue_valid && issue_ready;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    a_reg_form_time: assert property (
        tk && opcode[7:3] inside {5'h05, 5'h07, 5'h13, 5'h0B} |=> !done ##1 done)
        else $error("register form timing wrong");
    a_bank_reg_addr: assert property (
        tk && opcode[7:3] inside {5'h05, 5'h07, 5'h13, 5'h0B}
        |=> ram_addr == {3'h0, $past(status_word[4:3]), $past(opcode[2:0])})
        else $error("register address not in selected bank");
    a_two_cycle_time: assert property (
        tk && opcode inside {8'h24, 8'h95, 8'h94, 8'h54} |=> !done ##1 done)
        else $error("two cycle form timing wrong");
    a_three_cycle_time: assert property (
        tk && opcode inside {8'h25, 8'h35, 8'h55} |=> !done [*2] ##1 done)
        else $error("three cycle form timing wrong");
    a_four_cycle_time: assert property (
        tk && opcode inside {8'h36, 8'h37, 8'h96, 8'h97, 8'h56, 8'h57, 8'h05, 8'h15,
        8'h52, 8'h53} |=> !done [*3] ##1 done)
        else $error("four cycle form timing wrong");
    a_five_cycle_busy: assert property (
        tk && opcode inside {8'h06, 8'h07, 8'h16, 8'h17}
        |=> (!issue_ready && !done) [*4] ##1 (issue_ready && done))
        else $error("five cycle form timing wrong");
    a_ptr_reg_addr: assert property (
        tk && opcode[3:1] == 3'h3 && opcode[7:4] inside {4'h0, 4'h1, 4'h3, 4'h5, 4'h9}
        |=> ram_addr == {3'h0, $past(status_word[4:3]), 2'h0, $past(opcode[0])})
        else $error("pointer register address wrong");
    a_len_three: assert property (
        tk && opcode == 8'h53 |=> inst_len == 2'h3)
        else $error("three byte length wrong");
    a_add_imm_sum: assert property (
        tk && opcode == 8'h24 && !acc_we |-> ##2 acc == $past(acc, 2) + $past(operand1, 2))
        else $error("add immediate result wrong");
    a_and_imm_val: assert property (
        tk && opcode == 8'h54 && !acc_we |-> ##2 acc == ($past(acc, 2) & $past(operand1, 2)))
        else $error("and immediate result wrong");
    a_illegal_flag: assert property (
        tk && opcode == 8'h26 |=> illegal && !done && issue_ready)
        else $error("unsupported opcode not refused");
endmodule : cpu_arith_logic_decode_chk

bind cpu_arith_logic_decode cpu_arith_logic_decode_chk cpu_arith_logic_decode_chk_i (
    .core_clk(core_clk), .srst(srst), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .opcode(opcode), .operand1(operand1), .operand2(operand2), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_rdata(ram_rdata), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .status_we(status_we), .status_wdata(status_wdata), .acc(acc),
    .status_word(status_word), .inst_len(inst_len), .done(done), .illegal(illegal));

// *** testbench/cpu_arith_logic_decode_bench.sv ***
// Self-checking bench for the arithmetic and AND instruction sequencer
`timescale 1ns/1ps
module cpu_arith_logic_decode_bench;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic issue_valid = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [7:0] operand1 = 8'h00;
    logic [7:0] operand2 = 8'h00;
    logic acc_we = 1'b0;
    logic [7:0] acc_wdata = 8'h00;
    logic status_we = 1'b0;
    logic [7:0] status_wdata = 8'h00;
    logic issue_ready, ram_we, done, illegal;
    logic [7:0] ram_addr, ram_wdata, ram_rdata, acc, status_word;
    logic [1:0] inst_len;
    logic [7:0] mem [256];
    logic seen_ill;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    // Opcode, length, cycles
    logic [15:0] forms [23] = '{16'h2812, 16'h2F12, 16'h2523, 16'h2422, 16'h3812, 16'h3F12,
        16'h3523, 16'h3614, 16'h3714, 16'h9812, 16'h9522, 16'h9614, 16'h9422, 16'h0524,
        16'h0615, 16'h1524, 16'h1715, 16'h5812, 16'h5523, 16'h5614, 16'h5422, 16'h5224,
        16'h5334};

    cpu_arith_logic_decode cpu_arith_logic_decode_i (
        .core_clk(core_clk), .srst(srst), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .opcode(opcode), .operand1(operand1),
        .operand2(operand2), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
        .ram_rdata(ram_rdata), .acc_we(acc_we), .acc_wdata(acc_wdata),
        .status_we(status_we), .status_wdata(status_wdata), .acc(acc),
        .status_word(status_word), .inst_len(inst_len), .done(done), .illegal(illegal));

    // Internal data memory with same-cycle read
    assign ram_rdata = mem[ram_addr];
    always @(posedge core_clk) begin
        if (ram_we === 1'b1) begin
            mem[ram_addr] <= ram_wdata;
        end
    end

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("Checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic load(input logic [7:0] a, input logic [7:0] s);
        @(posedge core_clk);
        acc_we <= 1'b1;
        acc_wdata <= a;
        status_we <= 1'b1;
        status_wdata <= s;
        @(posedge core_clk);
        acc_we <= 1'b0;
        status_we <= 1'b0;
    endtask : load

    // Issue one instruction and count cycles until done or refusal
    task automatic run(input logic [7:0] op, input logic [7:0] a1, input logic [7:0] a2);
        @(posedge core_clk);
        issue_valid <= 1'b1;
        opcode <= op;
        operand1 <= a1;
        operand2 <= a2;
        @(posedge core_clk);
        issue_valid <= 1'b0;
        #1;
        n = 1;
        while (done !== 1'b1 && illegal !== 1'b1 && n < 9) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        seen_ill = (illegal === 1'b1);
    endtask : run

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = i[7:0];
        end
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        chk("reset acc", acc, 8'h00);
        chk("reset status", status_word, 8'h00);
        load(8'h3C, 8'h00);
        run(8'h25, 8'h40, 8'h00);
        chk("add direct", acc, 8'h7C);
        load(8'h01, 8'h18);
        run(8'h2A, 8'h00, 8'h00);
        chk("add bank3 reg", acc, 8'h1B);
        load(8'h10, 8'h80);
        run(8'h35, 8'h05, 8'h00);
        chk("add carry direct", acc, 8'h16);
        load(8'h10, 8'h80);
        run(8'h94, 8'h05, 8'h00);
        chk("sub borrow imm", acc, 8'h0A);
        chk("borrow out", {7'h00, status_word[7]}, 8'h00);
        load(8'h00, 8'h08);
        run(8'h07, 8'h00, 8'h00);
        chk("inc bank1 ptr1", mem[9], 8'h0A);
        run(8'h15, 8'h60, 8'h00);
        chk("dec direct", mem[8'h60], 8'h5F);
        run(8'h53, 8'h73, 8'h0F);
        chk("and imm direct", mem[8'h73], 8'h03);
        load(8'hF0, 8'h00);
        run(8'h52, 8'h3C, 8'h00);
        chk("and acc direct", mem[8'h3C], 8'h30);
        run(8'h26, 8'h00, 8'h00);
        chk("refused flag", {7'h00, seen_ill}, 8'h01);
        chk("refused acc", acc, 8'hF0);
        for (int i = 0; i < 23; i++) begin
            run(forms[i][15:8], 8'h80, 8'h00);
            chk("cycles", n[7:0], {4'h0, forms[i][3:0]});
            chk("length", {6'h00, inst_len}, {4'h0, forms[i][7:4]});
        end
        give_verdict();
    end
endmodule : cpu_arith_logic_decode_bench
